// File: core/nvm_shadow_pkg.sv
package nvm_shadow_pkg;

	// Array geometry
	localparam int NVM_ROWS     = 16;
	localparam int ROW_BITS     = 64;
	localparam int WORD_BITS    = 32;
	localparam int NVM_WORDS    = NVM_ROWS * ROW_BITS / WORD_BITS;
	localparam int SHADOW_WORDS = 24;

	// Internal 22-bit addresses of the shadow bank and command word
	localparam logic [21:0] SHADOW_FIRST_ADDR     = 22'h000080;
	localparam logic [21:0] SHADOW_LAST_ADDR      = 22'h0000AE;
	localparam logic [21:0] ADDR_STEP             = 22'h000002;
	localparam logic [21:0] INIT_SPEED_SETUP_ADDR = 22'h000080;
	localparam logic [21:0] SPINUP_CFG_A_ADDR     = 22'h000082;
	localparam logic [21:0] SPINUP_CFG_B_ADDR     = 22'h000084;
	localparam logic [21:0] FEEDBACK_CFG_A_ADDR   = 22'h000086;
	localparam logic [21:0] FEEDBACK_CFG_B_ADDR   = 22'h000088;
	localparam logic [21:0] FEEDBACK_CFG_C_ADDR   = 22'h00008A;
	localparam logic [21:0] FEEDBACK_CFG_D_ADDR   = 22'h00008C;
	localparam logic [21:0] SPEED_LOOP_ADDR       = 22'h00008E;
	localparam logic [21:0] POWER_REG_ADDR        = 22'h000090;
	localparam logic [21:0] PROTECTION_A_ADDR     = 22'h000092;
	localparam logic [21:0] PROTECTION_B_ADDR     = 22'h000094;
	localparam logic [21:0] WIDE_TWO_PHASE_ADDR   = 22'h000096;
	localparam logic [21:0] WIDE_THREE_PHASE_ADDR = 22'h000098;
	localparam logic [21:0] COMMUTATION_A_ADDR    = 22'h00009A;
	localparam logic [21:0] COMMUTATION_B_ADDR    = 22'h00009C;
	localparam logic [21:0] TERMINAL_FUNC_A_ADDR  = 22'h0000A4;
	localparam logic [21:0] TERMINAL_FUNC_B_ADDR  = 22'h0000A6;
	localparam logic [21:0] CHIP_SETUP_ADDR       = 22'h0000A8;
	localparam logic [21:0] GATE_DRIVE_A_ADDR     = 22'h0000AC;
	localparam logic [21:0] GATE_DRIVE_B_ADDR     = 22'h0000AE;
	localparam logic [21:0] NVM_COMMAND_ADDR      = 22'h0000E6;

	// Command words
	localparam logic [31:0] CMD_STORE  = 32'h80000000;
	localparam logic [31:0] CMD_RELOAD = 32'h40000000;
	localparam logic [31:0] CMD_CLEAR  = 32'h00000000;

	// Transfer length codes
	localparam logic [1:0] LEN_16 = 2'h0;
	localparam logic [1:0] LEN_32 = 2'h1;
	localparam logic [1:0] LEN_64 = 2'h2;

	// Timing
	localparam int CLK_MHZ       = 100;
	localparam int ERASE_TIME_US = 1000;
	localparam int PROG_TIME_US  = 1000;
	localparam int NVM_WAIT_MS   = 100;

	// Serial control word, first byte on the wire is the top byte
	typedef struct packed {
		logic        rd;
		logic        crc_en;
		logic [1:0]  transfer_length_field;
		logic [3:0]  address_section_field;
		logic [3:0]  page;
		logic [11:0] addr;
	} ctrl_word_t;

	// Result of decoding one internal address
	typedef struct packed {
		logic       hit_shadow;
		logic       hit_cmd;
		logic [4:0] idx;
	} addr_dec_t;

	typedef enum logic [2:0] {
		LK_IDLE   = 3'h0,
		LK_RX     = 3'h1,
		LK_RX_ACK = 3'h3,
		LK_TX     = 3'h2,
		LK_TX_ACK = 3'h6
	} link_state_t;

	typedef enum logic [1:0] {
		NV_IDLE  = 2'h0,
		NV_ERASE = 2'h1,
		NV_PROG  = 2'h3,
		NV_LOAD  = 2'h2
	} nvm_state_t;

endpackage : nvm_shadow_pkg

// File: core/eeprom_shadow_config_access.sv
`timescale 1ns/100ps
`default_nettype none

module eeprom_shadow_config_access #(
	parameter logic [6:0] TARGET_ID    = 7'h00,
	parameter int         ERASE_CYCLES = nvm_shadow_pkg::ERASE_TIME_US * nvm_shadow_pkg::CLK_MHZ,
	parameter int         PROG_CYCLES  = nvm_shadow_pkg::PROG_TIME_US * nvm_shadow_pkg::CLK_MHZ
) (
	input  wire logic        mclk_in,
	input  wire logic        reset_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	input  wire logic        motor_stopped_in,
	output logic             nvm_busy_out,
	output logic             cmd_refused_out,
	output logic [31:0]      chip_setup_out
);

	localparam logic [4:0] LAST_IDX  = 5'(nvm_shadow_pkg::SHADOW_WORDS - 1);
	localparam logic [4:0] CHIP_IDX  = 5'((nvm_shadow_pkg::CHIP_SETUP_ADDR
		- nvm_shadow_pkg::SHADOW_FIRST_ADDR) >> 1);
	localparam logic [23:0] ERASE_LD = 24'(ERASE_CYCLES - 1);
	localparam logic [23:0] PROG_LD  = 24'(PROG_CYCLES - 1);

	// array of 16 rows, two words each
	logic [31:0]                 nvm_mem [nvm_shadow_pkg::NVM_WORDS];
	logic [31:0]                 shadow_mem [nvm_shadow_pkg::SHADOW_WORDS];
	logic                        scl_s1_reg, scl_s2_reg, scl_d_reg;
	logic                        sda_s1_reg, sda_s2_reg, sda_d_reg;
	logic                        scl_rise, scl_fall, start_seen, stop_seen;
	nvm_shadow_pkg::link_state_t link_reg;
	logic [3:0]                  bit_cnt_reg;
	logic [3:0]                  byte_idx_reg;
	logic [7:0]                  shift_reg;
	logic                        ack_pend_reg, tx_mode_reg, mack_reg, oe_reg;
	logic [63:0]                 tx_sh_reg;
	logic [2:0]                  tx_left_reg;
	logic [7:0]                  rx_byte;
	logic                        rx_done, ack_next;
	logic                        wr_pkt_reg, wr_commit_reg;
	nvm_shadow_pkg::ctrl_word_t  ctrl_reg;
	logic [63:0]                 wbuf_reg;
	logic [3:0]                  len_bytes, data_pos;
	logic [21:0]                 addr0, addr1;
	nvm_shadow_pkg::addr_dec_t   dec0, dec1;
	logic [31:0]                 rd_word0, rd_word1;
	nvm_shadow_pkg::nvm_state_t  nv_reg;
	logic [4:0]                  idx_reg;
	logic [23:0]                 timer_reg;
	logic [31:0]                 cmd_reg;
	logic                        refused_reg, cmd_write;
	logic [31:0]                 chip_setup_reg;

	// shadow bank address window
	// Maps an internal address onto the shadow bank or command word
	function automatic nvm_shadow_pkg::addr_dec_t decode(input logic [21:0] a);
		nvm_shadow_pkg::addr_dec_t d;
		d = '0;
		if (a >= nvm_shadow_pkg::SHADOW_FIRST_ADDR && a <= nvm_shadow_pkg::SHADOW_LAST_ADDR
			&& !a[0]) begin
			d.hit_shadow = 1'b1;
			d.idx        = 5'((a - nvm_shadow_pkg::SHADOW_FIRST_ADDR) >> 1);
		end
		d.hit_cmd = (a == nvm_shadow_pkg::NVM_COMMAND_ADDR);
		return d;
	endfunction : decode

	// Bytes carried by a length code, zero for the reserved code
	function automatic logic [3:0] bytes_of(input logic [1:0] len);
		unique case (len)
			nvm_shadow_pkg::LEN_16: bytes_of = 4'h2;
			nvm_shadow_pkg::LEN_32: bytes_of = 4'h4;
			nvm_shadow_pkg::LEN_64: bytes_of = 4'h8;
			default:                bytes_of = 4'h0;
		endcase
	endfunction : bytes_of

	// Two-stage synchronisers plus one delay stage for edge detection
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_d_reg  <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_d_reg  <= 1'b1;
		end else begin
			scl_s1_reg <= scl_in;
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg  <= scl_s2_reg;
			sda_s1_reg <= sda_in;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg  <= sda_s2_reg;
		end
	end

	// Bus conditions
	assign scl_rise   = scl_s2_reg & ~scl_d_reg;
	assign scl_fall   = ~scl_s2_reg & scl_d_reg;
	assign start_seen = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop_seen  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
	assign rx_byte    = {shift_reg[6:0], sda_s2_reg};
	assign rx_done    = (link_reg == nvm_shadow_pkg::LK_RX) && scl_rise && bit_cnt_reg == 4'h7;
	assign len_bytes  = bytes_of(ctrl_reg.transfer_length_field);
	assign data_pos   = byte_idx_reg - 4'h4;

	// read ack: refused while the array is busy
	assign ack_next = (byte_idx_reg != 4'h0) ? 1'b1 :
		(rx_byte[7:1] == TARGET_ID) && (!rx_byte[0] ||
		(ctrl_reg.rd && nv_reg == nvm_shadow_pkg::NV_IDLE && len_bytes != 4'h0));

	// internal address, second word at plus two
	assign addr0 = 22'({ctrl_reg.address_section_field, ctrl_reg.page, ctrl_reg.addr});
	assign addr1 = addr0 + nvm_shadow_pkg::ADDR_STEP;
	assign dec0  = decode(addr0);
	assign dec1  = decode(addr1);

	// Read data for both words of a transfer
	always_comb begin
		rd_word0 = 32'h00000000;
		rd_word1 = 32'h00000000;
		if (dec0.hit_shadow) begin
			rd_word0 = shadow_mem[dec0.idx];
		end else if (dec0.hit_cmd) begin
			rd_word0 = cmd_reg;
		end
		if (ctrl_reg.transfer_length_field == nvm_shadow_pkg::LEN_16) begin
			rd_word0 = {16'h0000, rd_word0[15:0]};
		end
		if (dec1.hit_shadow) begin
			rd_word1 = shadow_mem[dec1.idx];
		end else if (dec1.hit_cmd) begin
			rd_word1 = cmd_reg;
		end
	end

	// Serial target bit engine
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			link_reg     <= nvm_shadow_pkg::LK_IDLE;
			bit_cnt_reg  <= 4'h0;
			byte_idx_reg <= 4'h0;
			shift_reg    <= 8'h00;
			ack_pend_reg <= 1'b0;
			tx_mode_reg  <= 1'b0;
			mack_reg     <= 1'b0;
			oe_reg       <= 1'b0;
			tx_sh_reg    <= 64'h0;
			tx_left_reg  <= 3'h0;
		end else if (start_seen) begin
			link_reg     <= nvm_shadow_pkg::LK_RX;
			bit_cnt_reg  <= 4'h0;
			byte_idx_reg <= 4'h0;
			oe_reg       <= 1'b0;
		end else if (stop_seen) begin
			link_reg <= nvm_shadow_pkg::LK_IDLE;
			oe_reg   <= 1'b0;
		end else begin
			unique case (link_reg)
				nvm_shadow_pkg::LK_IDLE: begin
					oe_reg <= 1'b0;
				end
				nvm_shadow_pkg::LK_RX: begin
					if (scl_rise) begin
						shift_reg   <= rx_byte;
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (rx_done) begin
							ack_pend_reg <= ack_next;
							tx_mode_reg  <= (byte_idx_reg == 4'h0) && rx_byte[0];
						end
					end else if (scl_fall && bit_cnt_reg == 4'h8) begin
						oe_reg   <= ack_pend_reg;
						link_reg <= ack_pend_reg ? nvm_shadow_pkg::LK_RX_ACK
							: nvm_shadow_pkg::LK_IDLE;
					end
				end
				nvm_shadow_pkg::LK_RX_ACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (byte_idx_reg != 4'hF) begin
							byte_idx_reg <= byte_idx_reg + 4'h1;
						end
						// first word first, low byte first, each byte high bit first
						if (tx_mode_reg) begin
							tx_sh_reg   <= {rd_word1, rd_word0};
							oe_reg      <= ~rd_word0[7];
							tx_left_reg <= 3'(len_bytes - 4'h1);
							link_reg    <= nvm_shadow_pkg::LK_TX;
						end else begin
							oe_reg   <= 1'b0;
							link_reg <= nvm_shadow_pkg::LK_RX;
						end
					end
				end
				nvm_shadow_pkg::LK_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							oe_reg   <= 1'b0;
							link_reg <= nvm_shadow_pkg::LK_TX_ACK;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							oe_reg      <= ~tx_sh_reg[3'(3'h6 - bit_cnt_reg[2:0])];
						end
					end
				end
				nvm_shadow_pkg::LK_TX_ACK: begin
					if (scl_rise) begin
						mack_reg <= ~sda_s2_reg;
					end else if (scl_fall) begin
						if (mack_reg && tx_left_reg != 3'h0) begin
							tx_sh_reg   <= tx_sh_reg >> 8;
							oe_reg      <= ~tx_sh_reg[15];
							tx_left_reg <= tx_left_reg - 3'h1;
							bit_cnt_reg <= 4'h0;
							link_reg    <= nvm_shadow_pkg::LK_TX;
						end else begin
							link_reg <= nvm_shadow_pkg::LK_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Control word and write data capture
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			wr_pkt_reg    <= 1'b0;
			wr_commit_reg <= 1'b0;
			ctrl_reg      <= '0;
			wbuf_reg      <= 64'h0;
		end else begin
			wr_commit_reg <= 1'b0;
			if (rx_done) begin
				if (byte_idx_reg == 4'h0) begin
					wr_pkt_reg <= ack_next && !rx_byte[0];
				end else if (wr_pkt_reg && byte_idx_reg < 4'h4) begin
					ctrl_reg <= {ctrl_reg[15:0], rx_byte};
				end else if (wr_pkt_reg && data_pos < len_bytes) begin
					wbuf_reg[{data_pos[2:0], 3'h0} +: 8] <= rx_byte;
					wr_commit_reg <= (data_pos == len_bytes - 4'h1) && !ctrl_reg.rd;
				end
			end
		end
	end

	// Shadow bank: reload has priority over serial writes
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			for (int i = 0; i < nvm_shadow_pkg::SHADOW_WORDS; i++) begin
				shadow_mem[i] <= 32'h00000000;
			end
		end else if (nv_reg == nvm_shadow_pkg::NV_LOAD) begin
			shadow_mem[idx_reg] <= nvm_mem[idx_reg];
		end else if (wr_commit_reg) begin
			if (dec0.hit_shadow) begin
				shadow_mem[dec0.idx] <=
					(ctrl_reg.transfer_length_field == nvm_shadow_pkg::LEN_16)
					? {shadow_mem[dec0.idx][31:16], wbuf_reg[15:0]} : wbuf_reg[31:0];
			end
			if (ctrl_reg.transfer_length_field == nvm_shadow_pkg::LEN_64 && dec1.hit_shadow) begin
				shadow_mem[dec1.idx] <= wbuf_reg[63:32];
			end
		end
	end

	assign cmd_write = wr_commit_reg && dec0.hit_cmd
		&& ctrl_reg.transfer_length_field == nvm_shadow_pkg::LEN_32;

	// Store and reload sequencer with command word
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			nv_reg      <= nvm_shadow_pkg::NV_IDLE;
			idx_reg     <= 5'h00;
			timer_reg   <= 24'h000000;
			cmd_reg     <= nvm_shadow_pkg::CMD_CLEAR;
			refused_reg <= 1'b0;
		end else begin
			refused_reg <= 1'b0;
			unique case (nv_reg)
				nvm_shadow_pkg::NV_IDLE: begin
					if (cmd_write) begin
						if (!motor_stopped_in && (wbuf_reg[31:0] == nvm_shadow_pkg::CMD_STORE
							|| wbuf_reg[31:0] == nvm_shadow_pkg::CMD_RELOAD)) begin
							refused_reg <= 1'b1;
						end else if (wbuf_reg[31:0] == nvm_shadow_pkg::CMD_STORE) begin
							cmd_reg   <= wbuf_reg[31:0];
							idx_reg   <= 5'h00;
							timer_reg <= ERASE_LD;
							nv_reg    <= nvm_shadow_pkg::NV_ERASE;
						end else if (wbuf_reg[31:0] == nvm_shadow_pkg::CMD_RELOAD) begin
							cmd_reg <= wbuf_reg[31:0];
							idx_reg <= 5'h00;
							nv_reg  <= nvm_shadow_pkg::NV_LOAD;
						end else begin
							cmd_reg <= wbuf_reg[31:0];
						end
					end
				end
				nvm_shadow_pkg::NV_ERASE: begin
					if (timer_reg == 24'h000000) begin
						timer_reg <= PROG_LD;
						nv_reg    <= nvm_shadow_pkg::NV_PROG;
					end else begin
						timer_reg <= timer_reg - 24'h000001;
					end
				end
				nvm_shadow_pkg::NV_PROG: begin
					if (timer_reg != 24'h000000) begin
						timer_reg <= timer_reg - 24'h000001;
					end else if (idx_reg == LAST_IDX) begin
						cmd_reg <= nvm_shadow_pkg::CMD_CLEAR;
						nv_reg  <= nvm_shadow_pkg::NV_IDLE;
					end else begin
						idx_reg   <= idx_reg + 5'h01;
						timer_reg <= idx_reg[0] ? ERASE_LD : PROG_LD;
						nv_reg    <= idx_reg[0] ? nvm_shadow_pkg::NV_ERASE : nvm_shadow_pkg::NV_PROG;
					end
				end
				nvm_shadow_pkg::NV_LOAD: begin
					if (idx_reg == LAST_IDX) begin
						cmd_reg <= nvm_shadow_pkg::CMD_CLEAR;
						nv_reg  <= nvm_shadow_pkg::NV_IDLE;
					end else begin
						idx_reg <= idx_reg + 5'h01;
					end
				end
			endcase
		end
	end

	// Nonvolatile array, written only by the sequencer
	always_ff @(posedge mclk_in) begin
		if (nv_reg == nvm_shadow_pkg::NV_ERASE && timer_reg == 24'h000000) begin
			nvm_mem[{idx_reg[4:1], 1'b0}] <= 32'h00000000;
			nvm_mem[{idx_reg[4:1], 1'b1}] <= 32'h00000000;
		end
		if (nv_reg == nvm_shadow_pkg::NV_PROG && timer_reg == 24'h000000) begin
			nvm_mem[idx_reg] <= shadow_mem[idx_reg];
		end
	end

	// chip setup group drives the device
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			chip_setup_reg <= 32'h00000000;
		end else begin
			chip_setup_reg <= shadow_mem[CHIP_IDX];
		end
	end

	assign sda_out         = 1'b0;
	assign sda_oe_out      = oe_reg;
	assign nvm_busy_out    = (nv_reg != nvm_shadow_pkg::NV_IDLE);
	assign cmd_refused_out = refused_reg;
	assign chip_setup_out  = chip_setup_reg;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	refuse_turning_a: assert property (
		cmd_write && !motor_stopped_in && nv_reg == nvm_shadow_pkg::NV_IDLE
		&& wbuf_reg[31:0] == nvm_shadow_pkg::CMD_STORE |=> !nvm_busy_out && cmd_refused_out)
		else $error("store started while motor turning");
	store_start_a: assert property (
		cmd_write && motor_stopped_in && nv_reg == nvm_shadow_pkg::NV_IDLE
		&& wbuf_reg[31:0] == nvm_shadow_pkg::CMD_STORE |=> nv_reg == nvm_shadow_pkg::NV_ERASE)
		else $error("store command did not start erase");
	reload_start_a: assert property (
		cmd_write && motor_stopped_in && nv_reg == nvm_shadow_pkg::NV_IDLE
		&& wbuf_reg[31:0] == nvm_shadow_pkg::CMD_RELOAD |=> nv_reg == nvm_shadow_pkg::NV_LOAD)
		else $error("reload command did not start reload");
	reload_length_a: assert property (
		$rose(nv_reg == nvm_shadow_pkg::NV_LOAD) |-> ##24 nv_reg == nvm_shadow_pkg::NV_IDLE)
		else $error("reload did not take 24 cycles");
	row_erase_a: assert property (
		nv_reg == nvm_shadow_pkg::NV_ERASE && timer_reg == 24'h000000
		|=> nvm_mem[{$past(idx_reg[4:1]), 1'b0}] == 32'h0
		&& nvm_mem[{$past(idx_reg[4:1]), 1'b1}] == 32'h0)
		else $error("row not cleared by erase");
	word_program_a: assert property (
		nv_reg == nvm_shadow_pkg::NV_PROG && timer_reg == 24'h000000
		|=> nvm_mem[$past(idx_reg)] == shadow_mem[$past(idx_reg)])
		else $error("programmed word differs from shadow");
	second_word_a: assert property (
		wr_commit_reg && nv_reg != nvm_shadow_pkg::NV_LOAD && dec1.hit_shadow
		&& ctrl_reg.transfer_length_field == nvm_shadow_pkg::LEN_64
		|=> shadow_mem[$past(dec1.idx)] == $past(wbuf_reg[63:32]))
		else $error("second word of 64-bit write lost");
	busy_read_nack_a: assert property (
		rx_done && byte_idx_reg == 4'h0 && rx_byte[0] && nvm_busy_out |-> !ack_next)
		else $error("read acknowledged while array busy");
	cmd_done_a: assert property (
		$fell(nvm_busy_out) |-> cmd_reg == nvm_shadow_pkg::CMD_CLEAR)
		else $error("command word not cleared after operation");

endmodule : eeprom_shadow_config_access

`default_nettype wire

// File: verification/nvm_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module nvm_host_model #(
	parameter logic [6:0] ID = 7'h00,
	parameter int         Q  = 5
) (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_drive_out
);
	// Bus idles released with the clock high
	initial begin
		scl_out = 1'b1;
		sda_drive_out = 1'b0;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge clk_in);
	endtask : tk

	// One bit out, line level sampled mid high
	task automatic bit_io(input logic b, output logic s);
		sda_drive_out <= ~b;
		tk(Q);
		scl_out <= 1'b1;
		tk(Q);
		s = sda_in;
		tk(Q);
		scl_out <= 1'b0;
		tk(Q);
	endtask : bit_io

	task automatic byte_io(input logic [7:0] wb, input logic last, output logic [7:0] rb,
			output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(wb[i], s);
			rb[i] = s;
		end
		bit_io(last, s);
		acked = ~s;
	endtask : byte_io

	// Start or repeated start
	task automatic start();
		sda_drive_out <= 1'b0;
		tk(Q);
		scl_out <= 1'b1;
		tk(Q);
		sda_drive_out <= 1'b1;
		tk(Q);
		scl_out <= 1'b0;
		tk(Q);
	endtask : start

	task automatic stop();
		sda_drive_out <= 1'b1;
		tk(Q);
		scl_out <= 1'b1;
		tk(Q);
		sda_drive_out <= 1'b0;
		tk(2 * Q);
	endtask : stop

	// Control word then n data bytes, ok when all acked
	task automatic wr(input logic [23:0] cw, input logic [63:0] d, input int n, output logic ok);
		logic [7:0] rb;
		logic       a;
		start();
		byte_io({ID, 1'b0}, 1'b1, rb, ok);
		for (int i = 2; i >= 0; i--) begin
			byte_io(cw[8*i +: 8], 1'b1, rb, a);
			ok &= a;
		end
		for (int i = 0; i < n; i++) begin
			byte_io(d[8*i +: 8], 1'b1, rb, a);
			ok &= a;
		end
		stop();
	endtask : wr

	task automatic rd(input logic [23:0] cw, input int n, output logic [63:0] d, output logic ok);
		logic [7:0] rb;
		logic       a;
		wr(cw, 64'h0, 0, ok);
		a = 1'b0;
		// Retry read id while refused
		for (int k = 0; k < 20 && !a; k++) begin
			start();
			byte_io({ID, 1'b1}, 1'b1, rb, a);
		end
		ok &= a;
		d = '0;
		for (int i = 0; i < n; i++) begin
			byte_io(8'hFF, i == n - 1, rb, a);
			d[8*i +: 8] = rb;
		end
		stop();
	endtask : rd
endmodule : nvm_host_model

`default_nettype wire

// File: verification/tb_eeprom_shadow_config_access.sv
`timescale 1ns/100ps
`default_nettype none

module tb_eeprom_shadow_config_access;
	logic        mclk_in          = 1'b0;
	logic        reset_in         = 1'b1;
	logic        motor_stopped_in = 1'b1;
	wire logic   scl, host_drive, sda_out, sda_oe, busy, refused, sda_line;
	wire logic [31:0] chip_setup;
	logic [31:0] exp_w [24];
	logic [31:0] rng = 32'h995D08D0;
	logic [63:0] rdat;
	logic        ok;
	int          errors    = 0;
	int          cmp_count = 0;
	int          busy_cnt  = 0;
	int          refused_cnt = 0;
	localparam logic [11:0] CMDA = nvm_shadow_pkg::NVM_COMMAND_ADDR[11:0];

	always #5 mclk_in = ~mclk_in;

	// Open-drain data line with pull-up
	assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_drive;

	eeprom_shadow_config_access #(.TARGET_ID(7'h00), .ERASE_CYCLES(4), .PROG_CYCLES(3)) dut (
		.mclk_in(mclk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_out(sda_oe), .motor_stopped_in(motor_stopped_in),
		.nvm_busy_out(busy), .cmd_refused_out(refused), .chip_setup_out(chip_setup));

	nvm_host_model host (.clk_in(mclk_in), .sda_in(sda_line), .scl_out(scl),
		.sda_drive_out(host_drive));

	// Cycle counts of busy and refusal pulses
	always @(posedge mclk_in) begin
		busy_cnt    <= busy_cnt + int'(busy === 1'b1);
		refused_cnt <= refused_cnt + int'(refused === 1'b1);
	end

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd

	function automatic logic [23:0] cw(input logic r, input logic [1:0] len,
			input logic [3:0] sec, input logic [11:0] a);
		nvm_shadow_pkg::ctrl_word_t c;
		c = '{rd: r, crc_en: 1'b0, transfer_length_field: len, address_section_field: sec,
			page: 4'h0, addr: a};
		return c;
	endfunction : cw

	// Address of shadow word i
	function automatic logic [11:0] sh(input int i);
		return nvm_shadow_pkg::SHADOW_FIRST_ADDR[11:0] + 12'(2 * i);
	endfunction : sh

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic finish_test();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	task automatic do_reset();
		@(posedge mclk_in);
		reset_in <= 1'b1;
		repeat (12) @(posedge mclk_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
	endtask : do_reset

	task automatic wr32(input logic [3:0] sec, input logic [11:0] a, input logic [31:0] d);
		host.wr(cw(1'b0, nvm_shadow_pkg::LEN_32, sec, a), {32'h0, d}, 4, ok);
		check({31'h0, ok}, 32'h1);
	endtask : wr32

	// Bounded wait for the sequencer to go idle
	task automatic wait_idle();
		int n;
		for (n = 0; n < 20000 && busy !== 1'b0; n++)
			@(posedge mclk_in);
		if (n == 20000) begin
			errors++;
			finish_test();
		end
		repeat (2) @(posedge mclk_in);
	endtask : wait_idle

	// Main sequence
	initial begin
		int          b0;
		int          b1;
		logic [31:0] w;
		do_reset();
		check(chip_setup, 32'h0);
		for (int i = 0; i < 12; i++) begin
			exp_w[2*i] = rnd();
			exp_w[2*i+1] = rnd();
			host.wr(cw(1'b0, nvm_shadow_pkg::LEN_64, 4'h0, sh(2*i)), {exp_w[2*i+1], exp_w[2*i]}, 8, ok);
			check({31'h0, ok}, 32'h1);
		end
		repeat (2) @(posedge mclk_in);
		check(chip_setup, exp_w[20]);
		b0 = busy_cnt;
		wr32(4'h0, CMDA, nvm_shadow_pkg::CMD_STORE);
		wait_idle();
		check({31'h0, busy_cnt > b0}, 32'h1);
		// Reset clears shadows only, reload restores them
		do_reset();
		check(chip_setup, 32'h0);
		b0 = busy_cnt;
		wr32(4'h0, CMDA, nvm_shadow_pkg::CMD_RELOAD);
		wait_idle();
		check(busy_cnt - b0, 32'd24);
		for (int i = 0; i < 12; i++) begin
			host.rd(cw(1'b1, nvm_shadow_pkg::LEN_64, 4'h0, sh(2*i)), 8, rdat, ok);
			check(rdat[31:0], exp_w[2*i]);
			check(rdat[63:32], exp_w[2*i+1]);
		end
		// Store and reload commands while the motor turns are refused
		@(posedge mclk_in);
		motor_stopped_in <= 1'b0;
		w = rnd();
		wr32(4'h0, sh(20), w);
		b0 = refused_cnt;
		b1 = busy_cnt;
		wr32(4'h0, CMDA, nvm_shadow_pkg::CMD_STORE);
		wr32(4'h0, CMDA, nvm_shadow_pkg::CMD_RELOAD);
		check(refused_cnt - b0, 32'd2);
		check(busy_cnt - b1, 32'd0);
		check(chip_setup, w);
		@(posedge mclk_in);
		motor_stopped_in <= 1'b1;
		wr32(4'h0, CMDA, nvm_shadow_pkg::CMD_RELOAD);
		wait_idle();
		check(chip_setup, exp_w[20]);
		// Section field is part of the address
		wr32(4'h1, sh(0), rnd());
		host.rd(cw(1'b1, nvm_shadow_pkg::LEN_32, 4'h0, sh(0)), 4, rdat, ok);
		check(rdat[31:0], exp_w[0]);
		host.rd(cw(1'b1, nvm_shadow_pkg::LEN_32, 4'h1, sh(0)), 4, rdat, ok);
		check(rdat[31:0], 32'h0);
		// Rewrite one shadow, store, then reload after reset
		w = rnd();
		wr32(4'h0, sh(3), w);
		b0 = busy_cnt;
		wr32(4'h0, CMDA, nvm_shadow_pkg::CMD_STORE);
		wait_idle();
		check(busy_cnt - b0, 32'd120);
		host.rd(cw(1'b1, nvm_shadow_pkg::LEN_32, 4'h0, CMDA), 4, rdat, ok);
		check(rdat[31:0], nvm_shadow_pkg::CMD_CLEAR);
		do_reset();
		wr32(4'h0, CMDA, nvm_shadow_pkg::CMD_RELOAD);
		wait_idle();
		host.rd(cw(1'b1, nvm_shadow_pkg::LEN_64, 4'h0, sh(3)), 8, rdat, ok);
		check(rdat[31:0], w);
		check(rdat[63:32], exp_w[4]);
		finish_test();
	end
endmodule : tb_eeprom_shadow_config_access

`default_nettype wire
